/* File: src/lcdpd_map.vh */
// Register map, field positions, reset values and timing counts
// for the segment display phase and blink logic.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef LCDPD_MAP_VH
`define LCDPD_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LCDPD_OFF_CTRL 6'h00
`define LCDPD_OFF_PEN 6'h04
`define LCDPD_OFF_BPEN 6'h08
`define LCDPD_OFF_BLINK 6'h0C
`define LCDPD_OFF_STATUS 6'h10
`define LCDPD_OFF_WF 6'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCDPD_CTRL_DUTY_LSB 0
`define LCDPD_CTRL_EN_BIT 3
`define LCDPD_BL_EN_BIT 0
`define LCDPD_BL_STYLE_BIT 1
`define LCDPD_BL_ALT_BIT 2
`define LCDPD_BL_BLANK_BIT 3
`define LCDPD_BL_RATE_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCDPD_RST_CTRL 4'h0
`define LCDPD_RST_PEN 8'h00
`define LCDPD_RST_BPEN 8'h00
`define LCDPD_RST_BLINK 7'h00
`define LCDPD_RST_WF 8'h00

// ----------------------------------------
// Duty codes and display modes
// ----------------------------------------
`define LCDPD_DUTY_2BP 3'h1
`define LCDPD_DUTY_4BP 3'h3
`define LCDPD_DUTY_8BP 3'h7
`define LCDPD_MODE_NORMAL 2'h0
`define LCDPD_MODE_BLANK 2'h1
`define LCDPD_MODE_ALT 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define LCDPD_CLK_HZ 10000000
`define LCDPD_SEGCLK_HZ 32768
`define LCDPD_SEGCLK_DIV (`LCDPD_CLK_HZ / `LCDPD_SEGCLK_HZ)
`define LCDPD_PHASE_TICKS 128
`define LCDPD_BLINK_DIV0 4096
`define LCDPD_BLINK_HALF0 (`LCDPD_BLINK_DIV0 / 2)

`endif

/* File: src/lcdpd_pin.v */
// One pin's drive decision: picks the waveform bit for the current phase.
// Assumes mode is already stable for the whole frame and phase for the whole phase.
`timescale 1ns/10ps
`include "lcdpd_map.vh"

module lcdpd_pin
(
	// Configuration
	input wire [7:0] wf,
	input wire [2:0] phase,
	input wire [1:0] mode,
	// Result
	output wire on
);
	wire [2:0] sel;

	// Alternate image lives in E..H; only reached with four phases or less
	assign sel = (mode == `LCDPD_MODE_ALT) ? {1'b1, phase[1:0]} : phase; // see R10
	// Same lookup serves backplanes and segments
	assign on = (mode != `LCDPD_MODE_BLANK) & wf[sel]; // see R2 see R4 see R7 see R8 see R9
endmodule // lcdpd_pin

/* File: src/lcdpd_top.v */
// Segment display phase sequencer, display mode and blink control,
// with an Avalon-MM register slave.
// Assumes one 10 MHz clock; bus inputs synchronous to it.
//
// Notes on behaviour
// R1: duty code 001 gives two phases, 011 four, 111 eight.
// R2: backplane waveform bit n selects active phase; bit 0 is A, bit 7 H.
// R3: each backplane-enable bit makes the matching pin a backplane.
// R4: frontplane waveform bit position names the phase of its segment.
// R5: only duty-count phases run, always in A-to-H order.
// R6: software sets pin enable, backplane enable and phase bit for a backplane.
// R7: frontplane bit one drives segment on, zero drives it off.
// R8: two bits choose display mode; normal, the default, uses stored bytes.
// R9: blank mode ignores waveform bytes and clears every segment.
// R10: alternate mode with four phases or less maps A-D onto E-H.
// R11: with five or more phases, alternate selection gives blank.
// R12: blinking only while blink enable set; else mode shown steadily.
// R13: blink period shows blank for style zero, alternate for style one.
// R14: with five or more phases, style one is ignored; blink period blank.
// R15: normal period blank, alternate or normal by bits; 5-8 blink blank.
// R16: phase sequence repeats once per frame in order.
// R17: blink rate is segment clock over divider chosen by rate field.
// R18: equal normal and blink halves; content changes only at frame ends.
`timescale 1ns/10ps
`include "lcdpd_map.vh"

module lcdpd_top
#(
	parameter NPINS = 8,
	parameter SEG_DIV = `LCDPD_SEGCLK_DIV,
	parameter PHASE_TICKS = `LCDPD_PHASE_TICKS,
	parameter BLINK_HALF0 = `LCDPD_BLINK_HALF0
)
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Avalon-MM slave
	input wire [5:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	// Panel pins
	output reg [NPINS-1:0] pin_on,
	output reg [NPINS-1:0] pin_is_bp,
	output reg [NPINS-1:0] pin_drive_en,
	// Sequencer status
	output reg [7:0] phase_onehot,
	output reg frame_start
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [3:0] ctrl;
	reg [7:0] pin_enable_reg;
	reg [7:0] backplane_enable_reg;
	reg [6:0] blink_control_reg;
	reg [7:0] waveform_bytes [0:NPINS-1];
	reg ack;

	wire [2:0] duty;
	wire lcd_en;
	wire blink_en;
	wire blink_style_select;
	wire alt_sel;
	wire blank_sel;
	wire [2:0] blink_rate_field;
	wire bus_req;
	wire wr_ok;
	wire wf_hit;
	wire [2:0] wf_idx;

	assign duty = ctrl[`LCDPD_CTRL_DUTY_LSB +: 3];
	assign lcd_en = ctrl[`LCDPD_CTRL_EN_BIT];
	assign blink_en = blink_control_reg[`LCDPD_BL_EN_BIT];
	assign blink_style_select = blink_control_reg[`LCDPD_BL_STYLE_BIT];
	assign alt_sel = blink_control_reg[`LCDPD_BL_ALT_BIT];
	assign blank_sel = blink_control_reg[`LCDPD_BL_BLANK_BIT];
	assign blink_rate_field = blink_control_reg[`LCDPD_BL_RATE_LSB +: 3];

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// Every access stalls one cycle so read data can come from a flop
	assign bus_req = read | write;
	assign waitrequest = bus_req & ~ack;
	// Write lands at the edge where waitrequest is seen low
	assign wr_ok = write & ack & byteenable[0];
	assign wf_hit = (address[5] == 1'b1) && (address[1:0] == 2'h0)
		&& ({1'b0, address[4:2]} < NPINS);
	assign wf_idx = address[4:2];

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			ack <= 1'b0;
		else
			ack <= bus_req & ~ack;
	end

	// ----------------------------------------
	// Sequencer and blink state
	// ----------------------------------------
	reg [8:0] seg_cnt;
	reg seg_tick;
	reg [7:0] ph_cnt;
	reg [2:0] phase;
	reg [18:0] blink_cnt;
	reg blink_req;
	reg blink_shown;
	reg [1:0] cur_mode;
	wire le4;
	wire frame_end;
	wire [18:0] blink_half;
	wire [31:0] blink_half_full;
	reg [1:0] next_mode;

	assign le4 = ~duty[2];
	assign frame_end = seg_tick && (ph_cnt == PHASE_TICKS - 1) && (phase == duty);
	// Longest half is 2048 << 7 = 2^18 ticks, so 19 bits hold it
	assign blink_half_full = BLINK_HALF0 << blink_rate_field; // see R17
	assign blink_half = blink_half_full[18:0];

	// ----------------------------------------
	// Register access
	// ----------------------------------------

	// Register read
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			readdata <= 32'h0;
		else if (read & ~ack)
		begin
			readdata <= 32'h0;
			case (address)
				`LCDPD_OFF_CTRL: readdata[3:0] <= ctrl;
				`LCDPD_OFF_PEN: readdata[7:0] <= pin_enable_reg;
				`LCDPD_OFF_BPEN: readdata[7:0] <= backplane_enable_reg;
				`LCDPD_OFF_BLINK: readdata[6:0] <= blink_control_reg;
				`LCDPD_OFF_STATUS: readdata[5:0] <= {blink_shown, cur_mode, phase};
				default:
				begin
					if (wf_hit)
						readdata[7:0] <= waveform_bytes[wf_idx];
				end
			endcase
		end
	end

	// Register write; unmapped addresses are ignored
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl <= `LCDPD_RST_CTRL;
			pin_enable_reg <= `LCDPD_RST_PEN;
			backplane_enable_reg <= `LCDPD_RST_BPEN;
			blink_control_reg <= `LCDPD_RST_BLINK; // see R8
		end
		else if (wr_ok)
		begin
			case (address)
				`LCDPD_OFF_CTRL: ctrl <= writedata[3:0];
				`LCDPD_OFF_PEN: pin_enable_reg <= writedata[7:0];
				`LCDPD_OFF_BPEN: backplane_enable_reg <= writedata[7:0]; // see R3
				`LCDPD_OFF_BLINK: blink_control_reg <= writedata[6:0];
				default:
				begin
				end
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi = gi + 1)
		begin : g_wf
			always @(posedge clk or posedge rst)
			begin
				if (rst)
					waveform_bytes[gi] <= `LCDPD_RST_WF;
				else if (wr_ok && wf_hit && (wf_idx == gi))
					waveform_bytes[gi] <= writedata[7:0];
			end
		end
	endgenerate

	// Segment clock tick derived from the system clock
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			seg_cnt <= 9'h0;
			seg_tick <= 1'b0;
		end
		else if (!lcd_en)
		begin
			seg_cnt <= 9'h0;
			seg_tick <= 1'b0;
		end
		else
		begin
			seg_tick <= (seg_cnt == SEG_DIV - 1);
			if (seg_cnt == SEG_DIV - 1)
				seg_cnt <= 9'h0;
			else
				seg_cnt <= seg_cnt + 9'h1;
		end
	end

	// Phase stepping: A upward to the duty count, then wrap
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ph_cnt <= 8'h0;
			phase <= 3'h0;
		end
		else if (!lcd_en)
		begin
			ph_cnt <= 8'h0;
			phase <= 3'h0;
		end
		else if (seg_tick)
		begin
			if (ph_cnt == PHASE_TICKS - 1)
			begin
				ph_cnt <= 8'h0;
				// Duty code equals the last phase index
				if (phase >= duty)
					phase <= 3'h0; // see R1 see R5 see R16
				else
					phase <= phase + 3'h1; // see R5 see R16
			end
			else
				ph_cnt <= ph_cnt + 8'h1;
		end
	end

	// ----------------------------------------
	// Blink and display mode
	// ----------------------------------------

	// Blink half-period timer on the segment clock
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			blink_cnt <= 19'h0;
			blink_req <= 1'b0;
		end
		else if (!blink_en || !lcd_en)
		begin
			blink_cnt <= 19'h0;
			blink_req <= 1'b0; // see R12
		end
		else if (seg_tick)
		begin
			if (blink_cnt >= blink_half - 19'h1)
			begin
				blink_cnt <= 19'h0;
				blink_req <= ~blink_req; // see R18
			end
			else
				blink_cnt <= blink_cnt + 19'h1;
		end
	end

	// Mode for the coming frame
	always @*
	begin
		next_mode = `LCDPD_MODE_NORMAL;
		if (blink_req)
		begin
			if (blink_style_select && le4)
				next_mode = `LCDPD_MODE_ALT; // see R13
			else
				next_mode = `LCDPD_MODE_BLANK; // see R13 see R14 see R15
		end
		else if (blank_sel)
			next_mode = `LCDPD_MODE_BLANK; // see R9 see R15
		else if (alt_sel)
			next_mode = le4 ? `LCDPD_MODE_ALT : `LCDPD_MODE_BLANK; // see R10 see R11
	end

	// Content switches only at frame ends or while the display is off, so no frame is torn
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cur_mode <= `LCDPD_MODE_NORMAL;
			blink_shown <= 1'b0;
		end
		else if (!lcd_en || frame_end)
		begin
			cur_mode <= next_mode; // see R18
			blink_shown <= blink_req;
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	wire [NPINS-1:0] next_on;

	generate
		for (gi = 0; gi < NPINS; gi = gi + 1)
		begin : g_pin
			lcdpd_pin u_pin
			(
				.wf(waveform_bytes[gi]),
				.phase(phase),
				.mode(cur_mode),
				.on(next_on[gi])
			);
		end
	endgenerate

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_on <= {NPINS{1'b0}};
			pin_is_bp <= {NPINS{1'b0}};
			pin_drive_en <= {NPINS{1'b0}};
			phase_onehot <= 8'h0;
			frame_start <= 1'b0;
		end
		else
		begin
			// Backplane needs pin enable and backplane enable both
			pin_drive_en <= lcd_en ? pin_enable_reg[NPINS-1:0] : {NPINS{1'b0}}; // see R6
			pin_is_bp <= backplane_enable_reg[NPINS-1:0]; // see R3
			pin_on <= lcd_en ? (next_on & pin_enable_reg[NPINS-1:0]) : {NPINS{1'b0}};
			phase_onehot <= lcd_en ? (8'h01 << phase) : 8'h0; // see R2
			frame_start <= frame_end;
		end
	end
endmodule // lcdpd_top

/* File: verification/lcdpd_checker.sv */
// Port checker for lcdpd_top.
// Assumes one clock and rst active high.
`timescale 1ns/10ps
module lcdpd_checker
#(
	parameter NPINS = 8
)
(
	// Clock and bus
	input wire clk,
	input wire rst,
	input wire read,
	input wire write,
	input wire waitrequest,
	input wire [31:0] readdata,
	// Panel
	input wire [NPINS-1:0] pin_on,
	input wire [NPINS-1:0] pin_drive_en,
	input wire [7:0] phase_onehot,
	input wire frame_start
);
	// --
	// Properties
	// --
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_hot; $onehot0(phase_onehot); endproperty
	a_hot: assert property (p_hot) else $error("phase not one-hot");
	property p_step;
		$past(phase_onehot) != 8'h00 && phase_onehot != 8'h00 && $changed(phase_onehot)
		|-> phase_onehot == ($past(phase_onehot) << 1) || phase_onehot == 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("phase order");
	property p_dwell; $changed(phase_onehot) && phase_onehot != 8'h00 |=> $stable(phase_onehot)[*3]; endproperty
	a_dwell: assert property (p_dwell) else $error("phase too short");
	property p_pulse; frame_start |=> !frame_start; endproperty
	a_pulse: assert property (p_pulse) else $error("frame pulse long");
	property p_fa; frame_start |=> phase_onehot == 8'h01; endproperty
	a_fa: assert property (p_fa) else $error("frame not at phase A");
	property p_drv; (pin_on & ~pin_drive_en) == 0; endproperty
	a_drv: assert property (p_drv) else $error("disabled pin active");
	property p_off; (phase_onehot == 8'h00)[*3] |-> pin_on == 0; endproperty
	a_off: assert property (p_off) else $error("pin active while idle");
	property p_wait; $rose(read || write) |-> waitrequest ##1 !waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_rd; read && !waitrequest |-> readdata[31:8] == 24'h0; endproperty
	a_rd: assert property (p_rd) else $error("upper read bits set");
	c_frame: cover property (frame_start);
	c_eight: cover property (phase_onehot == 8'h80);
	c_read: cover property (read && !waitrequest);
endmodule // lcdpd_checker

bind lcdpd_top lcdpd_checker #(.NPINS(NPINS)) u_chk (.clk(clk), .rst(rst), .read(read),
	.write(write), .waitrequest(waitrequest), .readdata(readdata), .pin_on(pin_on),
	.pin_drive_en(pin_drive_en), .phase_onehot(phase_onehot), .frame_start(frame_start));

/* File: verification/lcdpd_glass.sv */
// Glass model: records which segments lit during one frame.
// Assumes the pin outputs of lcdpd_top on one clock.
`timescale 1ns/10ps
module lcdpd_glass
(
	// Panel
	input wire clk,
	input wire [7:0] on,
	input wire [7:0] bp,
	input wire [7:0] en,
	input wire frame,
	// Segment f*8+b lit last frame
	output reg [63:0] lit
);
	reg [63:0] acc = 64'h0;
	reg [63:0] hit;
	integer f;
	integer b;
	always @*
	begin
		hit = 64'h0;
		for (f = 0; f < 8; f = f + 1)
			for (b = 0; b < 8; b = b + 1)
				if (on[f] & en[f] & ~bp[f] & on[b] & en[b] & bp[b])
					hit[f*8+b] = 1'b1;
	end
	// Pins seen with the frame pulse still belong to the old frame
	always @(posedge clk)
	begin
		if (frame)
		begin
			lit <= acc | hit;
			acc <= 64'h0;
		end
		else
			acc <= acc | hit;
	end
endmodule // lcdpd_glass

/* File: verification/lcdpd_top_tb.sv */
// Self-checking bench for lcdpd_top and a glass model.
// Assumes short timing parameters: a phase lasts four clocks.
`timescale 1ns/10ps
module lcdpd_top_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [5:0] address = 6'h00;
	reg read = 1'b0;
	reg write = 1'b0;
	reg [31:0] writedata = 32'h0;
	reg [3:0] byteenable = 4'hF;
	wire [31:0] readdata;
	wire waitrequest;
	wire [7:0] pin_on, pin_is_bp, pin_drive_en, phase_onehot;
	wire frame_start;
	wire [63:0] lit;
	integer errors = 0;
	integer checked = 0;
	integer cycles = 0;
	reg [31:0] rd;
	reg [7:0] fpw [0:3];
	lcdpd_top #(.SEG_DIV(2), .PHASE_TICKS(2), .BLINK_HALF0(4)) dut (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.pin_on(pin_on), .pin_is_bp(pin_is_bp), .pin_drive_en(pin_drive_en),
		.phase_onehot(phase_onehot), .frame_start(frame_start));
	lcdpd_glass glass (.clk(clk), .on(pin_on), .bp(pin_is_bp), .en(pin_drive_en),
		.frame(frame_start), .lit(lit));
	// --
	// Helpers
	// --
	initial forever #50 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			errors = errors + 1;
			wrap_up;
		end
	end
	task wrap_up;
	begin
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checked = checked + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask
	// Holds the request until waitrequest is sampled low at a rising edge
	task bus(input w, input [5:0] a, input [31:0] d);
	begin
		@(posedge clk);
		address <= a;
		read <= ~w;
		write <= w;
		writedata <= d;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	end
	endtask
	// Lit pattern of pins 4-7: normal, blank, alternate, eight phases
	function [31:0] img(input [1:0] m);
		integer i;
	begin
		img = 32'h0;
		for (i = 0; i < 4; i = i + 1)
			img[i*8 +: 4] = m == 2'h1 ? 4'h0 : m == 2'h2 ? fpw[i][7:4] :
				m == 2'h3 ? fpw[i][3:0] | fpw[i][7:4] : fpw[i][3:0];
	end
	endfunction
	task grab;
	begin
		@(posedge frame_start);
		@(posedge clk);
		@(negedge clk);
	end
	endtask
	task show(input [3:0] ctl, input [6:0] bl, input [31:0] exp);
	begin
		bus(1'b1, 6'h00, {28'h0, ctl});
		bus(1'b1, 6'h0C, {25'h0, bl});
		grab;
		grab;
		grab;
		chk(lit[63:32], exp);
	end
	endtask
	// Two frames per half with four phases, one with eight, so twelve frames hold six of each
	task blinkrun(input [6:0] bl, input [31:0] ea, input [31:0] eb);
		integer i, na, nb;
	begin
		bus(1'b1, 6'h0C, {25'h0, bl});
		na = 0;
		nb = 0;
		for (i = 0; i < 14; i = i + 1)
		begin
			grab;
			if (i > 1 && lit[63:32] === ea)
				na = na + 1;
			if (i > 1 && lit[63:32] === eb)
				nb = nb + 1;
		end
		chk(na, 6);
		chk(nb, 6);
	end
	endtask
	// --
	// Scenarios
	// --
	task t_regs;
		integer i;
	begin
		for (i = 0; i < 6; i = i + 1)
		begin
			bus(1'b0, (i < 5) ? 6'(i * 4) : 6'h20, 32'h0);
			chk(rd, 32'h0);
		end
		bus(1'b1, 6'h14, 32'hFF);
		bus(1'b0, 6'h14, 32'h0);
		chk(rd, 32'h0);
		byteenable <= 4'h0;
		bus(1'b1, 6'h08, 32'hFF);
		byteenable <= 4'hF;
		bus(1'b0, 6'h08, 32'h0);
		chk(rd, 32'h0);
	end
	endtask
	task t_setup;
		integer i;
	begin
		bus(1'b1, 6'h04, 32'hFF);
		bus(1'b1, 6'h08, 32'h0F);
		for (i = 0; i < 4; i = i + 1)
		begin
			bus(1'b1, 6'(32 + 4 * i), 32'h11 << i);
			bus(1'b1, 6'(48 + 4 * i), {24'h0, fpw[i]});
		end
		chk({24'h0, pin_is_bp}, 32'h0F);
	end
	endtask
	task t_period;
		integer i;
		time t;
	begin
		for (i = 0; i < 3; i = i + 1)
		begin
			bus(1'b1, 6'h00, 32'h8 | ((32'h2 << i) - 1));
			@(posedge frame_start);
			@(posedge frame_start);
			t = $time;
			@(posedge frame_start);
			chk(32'(($time - t) / 100), (32'h2 << i) * 4);
		end
	end
	endtask
	task t_image;
	begin
		show(4'hF, 7'h00, img(2'h3));
		show(4'hF, 7'h04, 32'h0);
		show(4'hB, 7'h00, img(2'h0));
		show(4'hB, 7'h08, 32'h0);
		bus(1'b0, 6'h10, 32'h0);
		chk(rd[4:3], 2'h1);
		show(4'hB, 7'h04, img(2'h2));
	end
	endtask
	task t_blink;
	begin
		blinkrun(7'h21, img(2'h0), 32'h0);
		blinkrun(7'h23, img(2'h0), img(2'h2));
		blinkrun(7'h2B, 32'h0, img(2'h2));
		blinkrun(7'h25, img(2'h2), 32'h0);
		bus(1'b1, 6'h00, 32'hF);
		blinkrun(7'h23, img(2'h3), 32'h0);
	end
	endtask
	initial
	begin
		fpw[0] = 8'h35;
		fpw[1] = 8'hA6;
		fpw[2] = 8'h1F;
		fpw[3] = 8'hC8;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_setup;
		t_period;
		t_image;
		t_blink;
		wrap_up;
	end
endmodule // lcdpd_top_tb
